// [core/dual_timer.sv]
`timescale 1ns/10ps
module dual_timer
	import timer_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire sfr_req_s    sfrReq,
	output logic      [7:0]  sfrRdData,
	input  wire vector_ack_s vectorAck,
	input  wire logic        timer0_count_pin,
	input  wire logic        timer1_count_pin,
	input  wire logic        ext_irq0_pin_n,
	input  wire logic        ext_irq1_pin_n,
	input  wire logic        extOscClk,
	output logic             timer0_overflow_flag,
	output logic             timer1_overflow_flag,
	output logic             ext_irq0_flag,
	output logic             ext_irq1_flag,
	output logic             timer1OverflowPulse
);

	typedef struct packed {
		logic [7:0] timer0_low_byte;
		logic [7:0] timer0_high_byte;
		logic [7:0] timer1_low_byte;
		logic [7:0] timer1_high_byte;
		logic [7:0] controlStatus;
		logic [7:0] modeSelect;
		logic [7:0] clockControl;
		logic [7:0] rdData;
		logic       t1Pulse;
	} timer_state_s;

	timer_state_s         q;
	timer_state_s         d;
	logic [PIN_COUNT-1:0] pinLevel;
	logic [PIN_COUNT-1:0] pinFall;
	logic                 presTick;
	timer_mode_e          timer0_mode_field;
	timer_mode_e          timer1_mode_field;
	logic                 split;
	logic                 clk0Tick;
	logic                 clk1Tick;
	logic                 t0Tick;
	logic                 t1Tick;
	logic                 t0Run;
	logic                 t1Run;
	logic                 hiSplitEn;
	logic [8:0]           hiSplitSum;
	timer_step_s          step0;
	timer_step_s          step1;
	logic                 t1FlagSet;
	logic                 wrCs;
	logic [7:0]           csBase;

	// One count step for modes 0 to 3 of either timer
	function automatic timer_step_s stepTimer(input timer_mode_e mode, input logic [7:0] lo,
	                                          input logic [7:0] hi, input logic en);
		timer_step_s r;
		logic [13:0] c13;
		logic [16:0] c16;
		logic [8:0]  c8;
		r   = '{ovf: 1'b0, hi: hi, lo: lo};
		c13 = {1'b0, hi, lo[4:0]} + 14'h0001;
		c16 = {1'b0, hi, lo} + 17'h00001;
		c8  = {1'b0, lo} + 9'h001;
		if (en) begin
			case (mode)
				MODE_13BIT: begin
					r.hi  = c13[12:5]; // Upper low-byte bits are left as stored
					r.lo  = {lo[7:5], c13[4:0]};
					r.ovf = c13[13]; // 0x1fff to 0x0000
				end
				MODE_16BIT: begin
					r.hi  = c16[15:8];
					r.lo  = c16[7:0];
					r.ovf = c16[16];
				end
				MODE_RELOAD8: begin
					r.lo  = c8[8] ? hi : c8[7:0]; // High byte stays the reload value
					r.ovf = c8[8];
				end
				MODE_SPLIT: begin
					r.lo  = c8[7:0];
					r.ovf = c8[8];
				end
				default: r = '{ovf: 1'b0, hi: hi, lo: lo};
			endcase
		end
		return r;
	endfunction : stepTimer

	pin_sampler u_pins (
		.clk_sys  (clk_sys),
		.rst_n    (rst_n),
		.pinsRaw  ({extOscClk, ext_irq1_pin_n, ext_irq0_pin_n, timer1_count_pin, timer0_count_pin}),
		.pinLevel (pinLevel),
		.pinFall  (pinFall)
	);

	prescaler u_prescale (
		.clk_sys       (clk_sys),
		.rst_n         (rst_n),
		.prescaleField (q.clockControl[CC_PRESCALE +: 2]),
		.extClkFall    (pinFall[PIN_EXTCLK]),
		.presTick      (presTick)
	);

	// Field decode of the mode register
	assign timer0_mode_field = timer_mode_e'(q.modeSelect[MS_T0_MODE +: 2]);
	assign timer1_mode_field = timer_mode_e'(q.modeSelect[MS_T1_MODE +: 2]);
	assign split             = (timer0_mode_field == MODE_SPLIT);

	// Clock source selection; clock-select matters in timer function, for the split high byte and for Timer 1 while split
	assign clk0Tick = q.clockControl[CC_T0_SYS] | presTick;
	assign clk1Tick = q.clockControl[CC_T1_SYS] | presTick;
	assign t0Tick   = q.modeSelect[MS_T0_CNT] ? pinFall[PIN_T0] : clk0Tick;
	assign t1Tick   = (q.modeSelect[MS_T1_CNT] & ~split) ? pinFall[PIN_T1] : clk1Tick;

	// Run qualification by run bit and gate pin
	assign t0Run = q.controlStatus[CS_T0_RUN] & (~q.modeSelect[MS_T0_GATE] | pinLevel[PIN_EXT_IRQ0_PIN_N]);
	// While split, the run bit belongs to the high byte, so the mode field and gate alone start Timer 1
	assign t1Run = (timer1_mode_field != MODE_SPLIT)
	             & (split | q.controlStatus[CS_T1_RUN])
	             & (~q.modeSelect[MS_T1_GATE] | pinLevel[PIN_EXT_IRQ1_PIN_N]);

	assign step0 = stepTimer(timer0_mode_field, q.timer0_low_byte, q.timer0_high_byte, t0Run & t0Tick);
	assign step1 = stepTimer(timer1_mode_field, q.timer1_low_byte, q.timer1_high_byte, t1Run & t1Tick);

	// Split high byte: clock ticks only, enabled by Timer 1 run
	assign hiSplitEn  = split & q.controlStatus[CS_T1_RUN] & clk0Tick;
	assign hiSplitSum = {1'b0, q.timer0_high_byte} + 9'h001;
	assign t1FlagSet  = split ? (hiSplitEn & hiSplitSum[8]) : step1.ovf;

	assign wrCs   = sfrReq.wrEn & (sfrReq.addr == ADDR_CONTROL_STATUS);
	assign csBase = wrCs ? sfrReq.wrData : q.controlStatus;

	// Next state: counting first, then software writes of count bytes win
	always_comb begin
		d                  = q;
		d.timer0_low_byte  = step0.lo;
		d.timer0_high_byte = split ? (hiSplitEn ? hiSplitSum[7:0] : q.timer0_high_byte) : step0.hi;
		d.timer1_low_byte  = step1.lo;
		d.timer1_high_byte = step1.hi;
		d.t1Pulse          = step1.ovf; // Baud and conversion users see it even when split

		// Run and type bits follow software; run does not touch the count
		d.controlStatus = csBase;
		// Hardware set beats software or vector clear
		d.controlStatus[CS_T0_FLAG] = step0.ovf | (csBase[CS_T0_FLAG] & ~vectorAck.timer0);
		d.controlStatus[CS_T1_FLAG] = t1FlagSet | (csBase[CS_T1_FLAG] & ~vectorAck.timer1);
		// Edge mode latches falls; level mode mirrors the inverted pin
		if (q.controlStatus[CS_X0_EDGE]) begin
			d.controlStatus[CS_X0_FLAG] = pinFall[PIN_EXT_IRQ0_PIN_N] | (csBase[CS_X0_FLAG] & ~vectorAck.ext0);
		end else begin
			d.controlStatus[CS_X0_FLAG] = ~pinLevel[PIN_EXT_IRQ0_PIN_N];
		end
		if (q.controlStatus[CS_X1_EDGE]) begin
			d.controlStatus[CS_X1_FLAG] = pinFall[PIN_EXT_IRQ1_PIN_N] | (csBase[CS_X1_FLAG] & ~vectorAck.ext1);
		end else begin
			d.controlStatus[CS_X1_FLAG] = ~pinLevel[PIN_EXT_IRQ1_PIN_N];
		end

		if (sfrReq.wrEn) begin
			case (sfrReq.addr)
				ADDR_MODE_SELECT:   d.modeSelect       = sfrReq.wrData;
				ADDR_CLOCK_CONTROL: d.clockControl     = sfrReq.wrData & CC_WRITE_MASK;
				ADDR_T0_LOW:        d.timer0_low_byte  = sfrReq.wrData;
				ADDR_T0_HIGH:       d.timer0_high_byte = sfrReq.wrData;
				ADDR_T1_LOW:        d.timer1_low_byte  = sfrReq.wrData;
				ADDR_T1_HIGH:       d.timer1_high_byte = sfrReq.wrData;
				default:            d.modeSelect       = q.modeSelect;
			endcase
		end

		// Registered read; unmapped addresses return zero
		case (sfrReq.addr)
			ADDR_CONTROL_STATUS: d.rdData = q.controlStatus;
			ADDR_MODE_SELECT:    d.rdData = q.modeSelect;
			ADDR_CLOCK_CONTROL:  d.rdData = q.clockControl & CC_WRITE_MASK;
			ADDR_T0_LOW:         d.rdData = q.timer0_low_byte;
			ADDR_T0_HIGH:        d.rdData = q.timer0_high_byte;
			ADDR_T1_LOW:         d.rdData = q.timer1_low_byte;
			ADDR_T1_HIGH:        d.rdData = q.timer1_high_byte;
			default:             d.rdData = RESET_BYTE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			q <= '{timer0_low_byte: RESET_BYTE, timer0_high_byte: RESET_BYTE,
			       timer1_low_byte: RESET_BYTE, timer1_high_byte: RESET_BYTE,
			       controlStatus: RESET_BYTE, modeSelect: RESET_BYTE,
			       clockControl: RESET_BYTE, rdData: RESET_BYTE, t1Pulse: 1'b0};
		end else begin
			q <= d;
		end
	end

	// Outputs straight from state flops
	assign sfrRdData            = q.rdData;
	assign timer0_overflow_flag = q.controlStatus[CS_T0_FLAG];
	assign timer1_overflow_flag = q.controlStatus[CS_T1_FLAG];
	assign ext_irq0_flag        = q.controlStatus[CS_X0_FLAG];
	assign ext_irq1_flag        = q.controlStatus[CS_X1_FLAG];
	assign timer1OverflowPulse  = q.t1Pulse;

endmodule : dual_timer

// [core/timer_pkg.sv]
package timer_pkg;

	// Special function register addresses
	localparam logic [7:0] ADDR_CONTROL_STATUS = 8'h88;
	localparam logic [7:0] ADDR_MODE_SELECT    = 8'h89;
	localparam logic [7:0] ADDR_T0_LOW         = 8'h8a;
	localparam logic [7:0] ADDR_T1_LOW         = 8'h8b;
	localparam logic [7:0] ADDR_T0_HIGH        = 8'h8c;
	localparam logic [7:0] ADDR_T1_HIGH        = 8'h8d;
	localparam logic [7:0] ADDR_CLOCK_CONTROL  = 8'h8e;

	// Values after reset
	localparam logic [7:0] RESET_BYTE = 8'h00;

	// Control/status bit positions
	localparam int CS_T1_FLAG  = 7;
	localparam int CS_T1_RUN   = 6;
	localparam int CS_T0_FLAG  = 5;
	localparam int CS_T0_RUN   = 4;
	localparam int CS_X1_FLAG  = 3;
	localparam int CS_X1_EDGE  = 2;
	localparam int CS_X0_FLAG  = 1;
	localparam int CS_X0_EDGE  = 0;

	// Mode register bit positions
	localparam int MS_T1_GATE  = 7;
	localparam int MS_T1_CNT   = 6;
	localparam int MS_T1_MODE  = 4;
	localparam int MS_T0_GATE  = 3;
	localparam int MS_T0_CNT   = 2;
	localparam int MS_T0_MODE  = 0;

	// Clock control bit positions and writable bits
	localparam int         CC_T1_SYS    = 4;
	localparam int         CC_T0_SYS    = 3;
	localparam int         CC_PRESCALE  = 0;
	localparam logic [7:0] CC_WRITE_MASK = 8'h1b;

	// Prescale divisors
	localparam logic [5:0] DIV_SYS12 = 6'h0c;
	localparam logic [5:0] DIV_SYS4  = 6'h04;
	localparam logic [5:0] DIV_SYS48 = 6'h30;
	localparam logic [5:0] DIV_EXT8  = 6'h08;

	// Sampled pin indices
	localparam int PIN_T0     = 0;
	localparam int PIN_T1     = 1;
	localparam int PIN_EXT_IRQ0_PIN_N   = 2;
	localparam int PIN_EXT_IRQ1_PIN_N   = 3;
	localparam int PIN_EXTCLK = 4;
	localparam int PIN_COUNT  = 5;

	typedef enum logic [1:0] {
		MODE_13BIT   = 2'b00,
		MODE_16BIT   = 2'b01,
		MODE_RELOAD8 = 2'b10,
		MODE_SPLIT   = 2'b11
	} timer_mode_e;

	typedef enum logic [1:0] {
		PRE_SYS12 = 2'b00,
		PRE_SYS4  = 2'b01,
		PRE_SYS48 = 2'b10,
		PRE_EXT8  = 2'b11
	} prescale_e;

	typedef struct packed {
		logic       wrEn;
		logic [7:0] addr;
		logic [7:0] wrData;
	} sfr_req_s;

	typedef struct packed {
		logic timer0;
		logic timer1;
		logic ext0;
		logic ext1;
	} vector_ack_s;

	typedef struct packed {
		logic       ovf;
		logic [7:0] hi;
		logic [7:0] lo;
	} timer_step_s;

endpackage : timer_pkg

// [core/pin_sampler.sv]
`timescale 1ns/10ps
module pin_sampler
	import timer_pkg::*;
(
	input  wire logic                 clk_sys,
	input  wire logic                 rst_n,
	input  wire logic [PIN_COUNT-1:0] pinsRaw,
	output logic      [PIN_COUNT-1:0] pinLevel,
	output logic      [PIN_COUNT-1:0] pinFall
);

	typedef struct packed {
		logic [PIN_COUNT-1:0] meta;
		logic [PIN_COUNT-1:0] sync;
		logic [PIN_COUNT-1:0] prev;
		logic [PIN_COUNT-1:0] fall;
	} sampler_s;

	sampler_s q;
	sampler_s d;

	// Two sync flops per pin; the edge compare takes the second stage and one more delay flop
	always_comb begin
		d      = q;
		d.meta = pinsRaw;
		d.sync = q.meta;
		d.prev = q.sync;
		d.fall = q.prev & ~q.sync; // One pulse per falling edge
	end

	// Idle high so no false edge shows after reset
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			q <= '{meta: '1, sync: '1, prev: '1, fall: '0};
		end else begin
			q <= d;
		end
	end

	assign pinLevel = q.sync;
	assign pinFall  = q.fall;

endmodule : pin_sampler

// [core/prescaler.sv]
`timescale 1ns/10ps
module prescaler
	import timer_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic [1:0] prescaleField,
	input  wire logic       extClkFall,
	output logic            presTick
);

	typedef struct packed {
		logic [5:0] count;
		logic       tick;
	} prescale_s;

	prescale_s  q;
	prescale_s  d;
	logic [5:0] limit;
	logic       advance;

	// Divisor and counting event per prescale code
	always_comb begin
		limit   = DIV_SYS12;
		advance = 1'b1;
		case (prescale_e'(prescaleField))
			PRE_SYS12: limit = DIV_SYS12;
			PRE_SYS4:  limit = DIV_SYS4;
			PRE_SYS48: limit = DIV_SYS48;
			PRE_EXT8: begin
				limit   = DIV_EXT8;
				advance = extClkFall; // Synchronised external edges
			end
			default:   limit = DIV_SYS12;
		endcase
	end

	// A field change mid-period just finishes against the new limit
	always_comb begin
		d      = q;
		d.tick = 1'b0;
		if (advance) begin
			if (q.count >= limit - 6'h01) begin
				d.count = 6'h00;
				d.tick  = 1'b1;
			end else begin
				d.count = q.count + 6'h01;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign presTick = q.tick;

endmodule : prescaler

// [bench/dual_timer_chk.sv]
`timescale 1ns/10ps
module dual_timer_chk
	import timer_pkg::*;
(
	input wire logic        clk_sys,
	input wire logic        rst_n,
	input wire sfr_req_s    sfrReq,
	input wire logic [7:0]  sfrRdData,
	input wire vector_ack_s vectorAck,
	input wire logic        ext_irq0_pin_n,
	input wire logic        timer0_overflow_flag,
	input wire logic        timer1_overflow_flag,
	input wire logic        ext_irq0_flag,
	input wire logic        timer1OverflowPulse
);
	logic [7:0] ctl_q;
	logic [7:0] mode_q;
	logic       ctlWr;

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	// Shadow of written control and mode bits; hardware-set flags are not tracked here
	assign ctlWr = sfrReq.wrEn && sfrReq.addr == ADDR_CONTROL_STATUS;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ctl_q  <= 8'h00;
			mode_q <= 8'h00;
		end else if (sfrReq.wrEn) begin
			if (sfrReq.addr == ADDR_CONTROL_STATUS) ctl_q <= sfrReq.wrData;
			if (sfrReq.addr == ADDR_MODE_SELECT) mode_q <= sfrReq.wrData;
		end
	end

	// Write then read of the mode register
	sequence sWrMode;
		sfrReq.wrEn && sfrReq.addr == ADDR_MODE_SELECT;
	endsequence
	sequence sRdMode;
		!sfrReq.wrEn && sfrReq.addr == ADDR_MODE_SELECT;
	endsequence

	AST_CC_UNUSED_ZERO: assert property (
		$past(sfrReq.addr) == ADDR_CLOCK_CONTROL |-> (sfrRdData & ~CC_WRITE_MASK) == 8'h00)
		else $error("clock control unused bits not zero");
	AST_MODE_READBACK: assert property (
		sWrMode ##1 sRdMode |=> sfrRdData == $past(sfrReq.wrData, 2))
		else $error("mode register read back differs");
	AST_T0_HOLD: assert property (
		!ctl_q[CS_T0_RUN] && !ctlWr && !vectorAck.timer0 |=> $stable(timer0_overflow_flag))
		else $error("timer 0 flag moved while stopped");
	AST_T1_HOLD: assert property (
		!ctl_q[CS_T1_RUN] && !ctlWr && !vectorAck.timer1 |=> $stable(timer1_overflow_flag))
		else $error("timer 1 flag moved while stopped");
	AST_T1_PULSE_FLAG: assert property (
		timer1OverflowPulse && mode_q[1:0] != 2'b11 |-> timer1_overflow_flag)
		else $error("timer 1 overflow without flag");
	AST_X0_LEVEL: assert property (
		(!ctl_q[CS_X0_EDGE] && $stable(ext_irq0_pin_n)) [*5] |-> ext_irq0_flag == !ext_irq0_pin_n)
		else $error("level flag does not mirror pin");
	AST_X0_EDGE_SET: assert property (
		ctl_q[CS_X0_EDGE] && $fell(ext_irq0_pin_n) |-> ##[1:6] ext_irq0_flag)
		else $error("falling edge not flagged");
	AST_X0_VEC_CLR: assert property (
		vectorAck.ext0 && ctl_q[CS_X0_EDGE] && !ctlWr && ext_irq0_pin_n && $past(ext_irq0_pin_n, 6)
		|=> !ext_irq0_flag)
		else $error("vectoring left edge flag set");
	AST_T0_VEC_CLR: assert property (
		vectorAck.timer0 && !ctl_q[CS_T0_RUN] && !ctlWr |=> !timer0_overflow_flag)
		else $error("vectoring left timer 0 flag set");
endmodule : dual_timer_chk

bind dual_timer dual_timer_chk chk (
	.clk_sys(clk_sys), .rst_n(rst_n), .sfrReq(sfrReq), .sfrRdData(sfrRdData), .vectorAck(vectorAck),
	.ext_irq0_pin_n(ext_irq0_pin_n), .timer0_overflow_flag(timer0_overflow_flag),
	.timer1_overflow_flag(timer1_overflow_flag), .ext_irq0_flag(ext_irq0_flag),
	.timer1OverflowPulse(timer1OverflowPulse));

// [bench/ext_pin_model.sv]
`timescale 1ns/10ps
module ext_pin_model (
	input  wire logic clk_sys,
	output logic      cntPin0,
	output logic      cntPin1,
	output logic      irqPin0N,
	output logic      irqPin1N,
	output logic      oscClk
);
	// Count and interrupt lines idle high, as pulled up when nothing pulls them low; the oscillator starts low
	initial begin
		cntPin0  = 1'b1;
		cntPin1  = 1'b1;
		irqPin0N = 1'b1;
		irqPin1N = 1'b1;
		oscClk   = 1'b0;
	end

	// Oscillator runs free at half the system rate, never above it
	always #20 oscClk = ~oscClk;

	// Low held three cycles and high at least three, so the sampler never misses one
	task automatic falls(input int i, input int n);
		repeat (n) begin
			@(posedge clk_sys);
			if (i == 0) cntPin0 <= 1'b0; else cntPin1 <= 1'b0;
			repeat (3) @(posedge clk_sys);
			if (i == 0) cntPin0 <= 1'b1; else cntPin1 <= 1'b1;
			repeat (3) @(posedge clk_sys);
		end
	endtask : falls

	task automatic setIrq(input int i, input logic lvl);
		@(posedge clk_sys);
		if (i == 0) irqPin0N <= lvl; else irqPin1N <= lvl;
	endtask : setIrq
endmodule : ext_pin_model

// [bench/tb_dual_timer.sv]
`timescale 1ns/10ps
module tb_dual_timer
	import timer_pkg::*;
();
	localparam logic [7:0] CTL = ADDR_CONTROL_STATUS;
	localparam logic [7:0] MOD = ADDR_MODE_SELECT;
	localparam logic [7:0] CKC = ADDR_CLOCK_CONTROL;
	logic        clk_sys = 1'b0;
	logic        rst_n;
	sfr_req_s    req;
	vector_ack_s vec;
	logic [7:0]  rdData;
	logic [4:0]  outs;
	wire         cnt0, cnt1, irq0N, irq1N, oscClk;
	int          miscompares = 0;
	int          cmp_count = 0;
	int          n;
	logic [7:0]  ccv [5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h08};
	int          div [5] = '{12, 4, 48, 16, 1};

	always #10 clk_sys = ~clk_sys;

	ext_pin_model pm (.clk_sys(clk_sys), .cntPin0(cnt0), .cntPin1(cnt1), .irqPin0N(irq0N), .irqPin1N(irq1N),
		.oscClk(oscClk));
	dual_timer dut (
		.clk_sys(clk_sys), .rst_n(rst_n), .sfrReq(req), .sfrRdData(rdData), .vectorAck(vec),
		.timer0_count_pin(cnt0), .timer1_count_pin(cnt1), .ext_irq0_pin_n(irq0N), .ext_irq1_pin_n(irq1N),
		.extOscClk(oscClk), .timer0_overflow_flag(outs[0]), .timer1_overflow_flag(outs[1]),
		.ext_irq0_flag(outs[2]), .ext_irq1_flag(outs[3]), .timer1OverflowPulse(outs[4]));

	task automatic complete_run();
		if (miscompares == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : complete_run

	task automatic chk(input string nm, input logic [7:0] e, g);
		cmp_count++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", nm, e, g);
			miscompares++;
		end
	endtask : chk

	// Writes stay back to back until idle or rd drops the strobe
	task automatic wr(input logic [7:0] a, d);
		@(posedge clk_sys);
		req <= '{1'b1, a, d};
	endtask : wr

	task automatic rd(input logic [7:0] a, e, input string nm);
		@(posedge clk_sys);
		req <= '{1'b0, a, 8'h00};
		@(posedge clk_sys);
		#1 chk(nm, e, rdData);
	endtask : rd

	task automatic idle(input int k);
		@(posedge clk_sys);
		req.wrEn <= 1'b0;
		repeat (k) @(posedge clk_sys);
		#1;
	endtask : idle

	task automatic vecPulse(input vector_ack_s v);
		@(posedge clk_sys);
		vec <= v;
		@(posedge clk_sys);
		vec <= '0;
		#1;
	endtask : vecPulse

	// Bounded wait on one flag; running out counts as a miscompare
	task automatic waitBit(input int b, input int lim);
		n = 0;
		while (outs[b] !== 1'b1) begin
			if (n >= lim) begin
				$display("ERROR wait%0d expected 1 seen %b", b, outs[b]);
				miscompares++;
				complete_run();
			end
			@(posedge clk_sys);
			#1 n++;
		end
	endtask : waitBit

	// Preload, run on external edges, then stop and read both bytes
	task automatic runCount(input int i, input logic [7:0] md, lo, hi, input int k, input logic [7:0] eLo, eHi,
			input logic eF);
		wr(MOD, md);
		wr(i ? ADDR_T1_LOW : ADDR_T0_LOW, lo);
		wr(i ? ADDR_T1_HIGH : ADDR_T0_HIGH, hi);
		wr(CTL, i ? 8'h40 : 8'h10);
		idle(2);
		pm.falls(i, k);
		idle(8);
		chk("flag", {7'h00, eF}, {7'h00, outs[i]});
		wr(CTL, 8'h00);
		rd(i ? ADDR_T1_LOW : ADDR_T0_LOW, eLo, "low");
		rd(i ? ADDR_T1_HIGH : ADDR_T0_HIGH, eHi, "high");
	endtask : runCount

	initial begin
		rst_n = 1'b0;
		req = '0;
		vec = '0;
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'b1;
		for (int a = 'h87; a <= 'h8f; a++) rd(8'(a), 8'h00, "reset");
		wr(CKC, 8'hff);
		rd(CKC, CC_WRITE_MASK, "clkctl");
		wr(MOD, 8'ha5);
		rd(MOD, 8'ha5, "mode");
		runCount(0, 8'h04, 8'h1e, 8'hff, 2, 8'h00, 8'h00, 1'b1);
		runCount(0, 8'h0d, 8'hfd, 8'hff, 3, 8'h00, 8'h00, 1'b1);
		runCount(0, 8'h06, 8'hfe, 8'h80, 3, 8'h81, 8'h80, 1'b1);
		runCount(1, 8'h50, 8'hfe, 8'hff, 2, 8'h00, 8'h00, 1'b1);
		pm.setIrq(0, 1'b0);
		runCount(0, 8'h0d, 8'hfe, 8'hff, 2, 8'hfe, 8'hff, 1'b0);
		pm.setIrq(0, 1'b1);
		// Two ticks of each clock source must land inside the divisor window
		for (int k = 0; k < 5; k++) begin
			wr(CTL, 8'h00);
			wr(CKC, ccv[k]);
			wr(MOD, 8'h01);
			wr(ADDR_T0_LOW, 8'hfe);
			wr(ADDR_T0_HIGH, 8'hff);
			wr(CTL, 8'h10);
			idle(0);
			waitBit(0, 2 * div[k] + 8);
			chk("ticks", 8'h01, {7'h00, n >= div[k] && n <= 2 * div[k] + 4});
		end
		// Clear written in the very cycle of the wrap
		wr(CTL, 8'h00);
		wr(ADDR_T0_LOW, 8'hff);
		wr(ADDR_T0_HIGH, 8'hff);
		wr(CTL, 8'h10);
		wr(CTL, 8'h10);
		idle(1);
		chk("ovfclr", 8'h01, {7'h00, outs[0]});
		wr(CTL, 8'h20);
		idle(1);
		vecPulse(4'b1000);
		chk("vecclr", 8'h00, {7'h00, outs[0]});
		// Split mode: high byte on run 1 and flag 1, low byte on edges
		wr(ADDR_T0_HIGH, 8'hf0);
		wr(ADDR_T0_LOW, 8'hfe);
		wr(MOD, 8'h37);
		wr(CTL, 8'h50);
		idle(0);
		waitBit(1, 40);
		pm.falls(0, 2);
		idle(8);
		chk("splitlo", 8'h01, {7'h00, outs[0]});
		wr(CTL, 8'h00);
		wr(CKC, 8'h10);
		wr(ADDR_T1_LOW, 8'hfe);
		wr(ADDR_T1_HIGH, 8'hff);
		idle(20);
		rd(ADDR_T1_LOW, 8'hfe, "t1off");
		wr(MOD, 8'h13);
		idle(0);
		waitBit(4, 20);
		chk("t1flag", 8'h00, {7'h00, outs[1]});
		// External interrupt in edge mode, then level mode
		wr(CTL, 8'h01);
		idle(2);
		pm.setIrq(0, 1'b0);
		idle(3);
		pm.setIrq(0, 1'b1);
		idle(6);
		chk("edge", 8'h01, {7'h00, outs[2]});
		vecPulse(4'b0010);
		chk("edgevec", 8'h00, {7'h00, outs[2]});
		wr(CTL, 8'h00);
		pm.setIrq(0, 1'b0);
		idle(6);
		chk("level", 8'h01, {7'h00, outs[2]});
		vecPulse(4'b0010);
		chk("levelvec", 8'h01, {7'h00, outs[2]});
		pm.setIrq(0, 1'b1);
		idle(6);
		chk("levelhi", 8'h00, {7'h00, outs[2]});
		complete_run();
	end
endmodule : tb_dual_timer
